/* File: src/iwd_pkg.sv */
package iwd_pkg;

  // Word and field geometry
  localparam int WORD_W        = 16;
  localparam int TARGET_W      = 20;
  localparam int LONG_W        = 12;
  localparam int OPC_W         = 8;
  localparam int BYTE_OPC_LSB  = 10;
  localparam int DEST_POS      = 9;
  localparam int BANK_POS      = 8;
  localparam int FILE_MSB      = 7;
  localparam int BIT_OPC_LSB   = 12;
  localparam int BITNUM_MSB    = 11;
  localparam int BITNUM_LSB    = 9;
  localparam int LIT_OPC_LSB   = 8;
  localparam int LONG_MSB      = 11;
  localparam int TAG_LSB       = 12;
  localparam int CALL_FLAG_POS = 8;
  localparam int CALL_OPC_LSB  = 9;
  localparam int REL_MSB       = 10;
  localparam int REL_OPC_LSB   = 11;

  // Upper nibble that marks the second word of a two-word instruction
  localparam logic [3:0] SECOND_TAG = 4'hF;

  // Instruction format, supplied by the predecode of the fetch path
  typedef enum logic [2:0] {
    FMT_BYTE   = 3'h0,
    FMT_BIT    = 3'h1,
    FMT_LIT    = 3'h2,
    FMT_MOVE   = 3'h3,
    FMT_JUMP   = 3'h4,
    FMT_CALL   = 3'h5,
    FMT_BRANCH = 3'h6,
    FMT_OTHER  = 3'h7
  } iwd_fmt_type;

  typedef enum logic {
    DEST_ACCUM = 1'b0,
    DEST_FILE  = 1'b1
  } iwd_dest_type;

  typedef enum logic {
    BANK_ACCESS  = 1'b0,
    BANK_POINTER = 1'b1
  } iwd_bank_type;

  // Raw fields cut from one word
  typedef struct packed {
    logic [5:0]   byte_opc;
    iwd_dest_type dest;
    iwd_bank_type bank;
    logic [7:0]   file_addr;
    logic [3:0]   bit_opc;
    logic [2:0]   bit_num;
    logic [7:0]   bit_mask;
    logic [7:0]   lit_opc;
    logic [7:0]   literal;
    logic [3:0]   tag;
    logic [11:0]  long_addr;
    logic [6:0]   call_opc;
    logic         call_flag;
    logic [4:0]   rel_opc;
    logic [10:0]  rel_off;
  } iwd_fields_type;

  // Decoded instruction handed to datapath and sequencer
  typedef struct packed {
    logic          valid;
    iwd_fmt_type   fmt;
    logic          is_nop;
    logic          pair_error;
    logic [7:0]    opcode;
    iwd_dest_type  dest;
    iwd_bank_type  bank;
    logic [7:0]    file_addr;
    logic [2:0]    bit_num;
    logic [7:0]    bit_mask;
    logic [7:0]    literal;
    logic [11:0]   src_addr;
    logic [11:0]   dst_addr;
    logic [19:0]   target;
    logic          fast_flag;
    logic [19:0]   rel_offset;
  } iwd_decode_type;

endpackage

/* File: src/iwd_field_split.sv */
`timescale 1ns/1ps
module iwd_field_split (
  // Instruction word
  input  wire logic [iwd_pkg::WORD_W-1:0] word,
  // Fields
  output iwd_pkg::iwd_fields_type         fields
);

  // One-hot selector of the addressed bit
  function automatic logic [7:0] bit_onehot(input logic [2:0] num);
    bit_onehot = 8'h01 << num;
  endfunction

  // Byte-oriented layout
  assign fields.byte_opc  = word[iwd_pkg::WORD_W-1:iwd_pkg::BYTE_OPC_LSB];
  assign fields.dest      = iwd_pkg::iwd_dest_type'(word[iwd_pkg::DEST_POS]);
  assign fields.bank      = iwd_pkg::iwd_bank_type'(word[iwd_pkg::BANK_POS]);
  assign fields.file_addr = word[iwd_pkg::FILE_MSB:0];

  // Bit-oriented layout
  assign fields.bit_opc   = word[iwd_pkg::WORD_W-1:iwd_pkg::BIT_OPC_LSB];
  assign fields.bit_num   = word[iwd_pkg::BITNUM_MSB:iwd_pkg::BITNUM_LSB];
  assign fields.bit_mask  = bit_onehot(word[iwd_pkg::BITNUM_MSB:iwd_pkg::BITNUM_LSB]);

  // Literal layout
  assign fields.lit_opc   = word[iwd_pkg::WORD_W-1:iwd_pkg::LIT_OPC_LSB];
  assign fields.literal   = word[iwd_pkg::FILE_MSB:0];

  // Long address and second-word marker
  assign fields.tag       = word[iwd_pkg::WORD_W-1:iwd_pkg::TAG_LSB];
  assign fields.long_addr = word[iwd_pkg::LONG_MSB:0];

  // Call and relative branch layouts
  assign fields.call_opc  = word[iwd_pkg::WORD_W-1:iwd_pkg::CALL_OPC_LSB];
  assign fields.call_flag = word[iwd_pkg::CALL_FLAG_POS];
  assign fields.rel_opc   = word[iwd_pkg::WORD_W-1:iwd_pkg::REL_OPC_LSB];
  assign fields.rel_off   = word[iwd_pkg::REL_MSB:0];

endmodule // iwd_field_split

/* File: src/iwd_decoder.sv */
`timescale 1ns/1ps
module iwd_decoder #(
  parameter int WORD_W = 16
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rstn,
  // Fetch path
  input  wire logic                  instr_valid,
  input  wire logic [WORD_W-1:0]     instr_word,
  input  iwd_pkg::iwd_fmt_type       instr_fmt,
  input  wire logic                  flush,
  // Datapath and sequencer
  output iwd_pkg::iwd_decode_type    dec,
  output logic                       wait_second
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter check

  // The field positions are fixed to a sixteen-bit word
  // Field positions come from the package, so another width cannot be served
  if (WORD_W != iwd_pkg::WORD_W) begin : g_bad_word_w
    $error("iwd_decoder: WORD_W must be sixteen");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field extraction

  // The splitter is purely combinational; every format's view exists each cycle
  iwd_pkg::iwd_fields_type fields;

  iwd_field_split u_split (
    .word   (instr_word),
    .fields (fields)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pair sequencer

  typedef enum logic {
    ST_FIRST  = 1'b0,
    ST_SECOND = 1'b1
  } iwd_state_type;

  iwd_state_type          state_q;
  iwd_state_type          state_d;
  iwd_pkg::iwd_fmt_type   hold_fmt_q;
  logic [7:0]             hold_opc_q;
  logic [7:0]             hold_low_q;
  logic [11:0]            hold_long_q;
  logic                   hold_flag_q;
  logic                   take;
  logic                   is_tagged;
  logic                   is_first_of_pair;
  logic                   open_pair;

  // An accepted word is one that a flush does not discard
  assign take      = instr_valid && !flush;
  assign is_tagged = (fields.tag == iwd_pkg::SECOND_TAG);

  // Formats whose first word waits for a tagged partner
  function automatic logic is_pair_fmt(input iwd_pkg::iwd_fmt_type fmt);
    is_pair_fmt = (fmt == iwd_pkg::FMT_MOVE) ||
                  (fmt == iwd_pkg::FMT_JUMP) ||
                  (fmt == iwd_pkg::FMT_CALL);
  endfunction

  assign is_first_of_pair = is_pair_fmt(instr_fmt);

  // A first word that opens a pair; only this loads the hold registers
  assign open_pair = take && (state_q == ST_FIRST) && !is_tagged && is_first_of_pair;

  // Next state; a flush drops a half-seen pair so no stale word is joined
  always_comb begin
    state_d = state_q;
    if (flush) begin
      state_d = ST_FIRST;
    end else if (instr_valid) begin
      unique case (state_q)
        ST_FIRST: begin
          if (!is_tagged && is_first_of_pair) begin
            state_d = ST_SECOND;
          end
        end
        ST_SECOND: begin
          state_d = ST_FIRST;
        end
      endcase
    end
  end

  // State register
  // A held first word survives any number of idle cycles
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_FIRST;
    end else begin
      state_q <= state_d;
    end
  end

  // First word of a pair is held until its partner arrives
  // Loading only on an opening word keeps a void pair from losing its opcode
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hold_fmt_q  <= iwd_pkg::FMT_OTHER;
      hold_opc_q  <= 8'h00;
      hold_low_q  <= 8'h00;
      hold_long_q <= 12'h000;
      hold_flag_q <= 1'b0;
    end else if (open_pair) begin
      hold_fmt_q  <= instr_fmt;
      hold_low_q  <= fields.literal;
      hold_long_q <= fields.long_addr;
      hold_flag_q <= (instr_fmt == iwd_pkg::FMT_CALL) && fields.call_flag;
      unique case (instr_fmt)
        iwd_pkg::FMT_MOVE: hold_opc_q <= 8'(fields.tag);
        iwd_pkg::FMT_CALL: hold_opc_q <= 8'(fields.call_opc);
        default:           hold_opc_q <= fields.lit_opc;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  iwd_pkg::iwd_decode_type dec_d;

  // Build the decoded record; the first word of a pair yields no record
  // Fields a format does not use stay zero so the datapath sees no stale bits
  always_comb begin
    dec_d       = '0;
    dec_d.fmt   = instr_fmt;
    dec_d.dest  = iwd_pkg::DEST_ACCUM;
    dec_d.bank  = iwd_pkg::BANK_ACCESS;
    if (take) begin
      if (state_q == ST_SECOND) begin
        dec_d.valid = 1'b1;
        dec_d.fmt   = hold_fmt_q;
        dec_d.opcode = hold_opc_q;
        if (!is_tagged) begin
          // Partner lacks its marker: the pair is void and nothing executes
          dec_d.is_nop     = 1'b1;
          dec_d.pair_error = 1'b1;
        end else if (hold_fmt_q == iwd_pkg::FMT_MOVE) begin
          dec_d.src_addr = hold_long_q;
          dec_d.dst_addr = fields.long_addr;
        end else begin
          dec_d.target    = {fields.long_addr, hold_low_q};
          dec_d.fast_flag = hold_flag_q;
        end
      end else if (is_tagged) begin
        dec_d.valid  = 1'b1;
        dec_d.fmt    = iwd_pkg::FMT_OTHER;
        dec_d.is_nop = 1'b1;
      end else if (!is_first_of_pair) begin
        dec_d.valid = 1'b1;
        unique case (instr_fmt)
          iwd_pkg::FMT_BYTE: begin
            dec_d.opcode    = 8'(fields.byte_opc);
            dec_d.dest      = fields.dest;
            dec_d.bank      = fields.bank;
            dec_d.file_addr = fields.file_addr;
          end
          iwd_pkg::FMT_BIT: begin
            dec_d.opcode    = 8'(fields.bit_opc);
            dec_d.bit_num   = fields.bit_num;
            dec_d.bit_mask  = fields.bit_mask;
            dec_d.bank      = fields.bank;
            dec_d.file_addr = fields.file_addr;
          end
          iwd_pkg::FMT_LIT: begin
            dec_d.opcode  = fields.lit_opc;
            dec_d.literal = fields.literal;
          end
          iwd_pkg::FMT_BRANCH: begin
            dec_d.opcode     = 8'(fields.rel_opc);
            dec_d.rel_offset = 20'(signed'(fields.rel_off));
          end
          default: begin
            // Other control words pass their top byte for the sequencer
            dec_d.opcode = fields.lit_opc;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers

  // Outputs come from flops so the datapath sees a clean record each cycle
  // One cycle of latency is traded for a record free of fetch-path glitches
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      dec <= '0;
    end else begin
      dec <= dec_d;
    end
  end

  // Tells the fetch path the next word is taken as a partner
  // Driven from the next state so it stands before the partner word arrives
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wait_second <= 1'b0;
    end else begin
      wait_second <= (state_d == ST_SECOND);
    end
  end

endmodule // iwd_decoder

/* File: tb/iwd_decoder_chk.sv */
`timescale 1ns/1ps
module iwd_decoder_chk #(
  parameter int WORD_W = 16
) (
  // Clock and reset
  input wire logic               ref_clk,
  input wire logic               rstn,
  // Fetch path
  input wire logic               instr_valid,
  input wire logic [WORD_W-1:0]  instr_word,
  input iwd_pkg::iwd_fmt_type    instr_fmt,
  input wire logic               flush,
  // Decoded output
  input iwd_pkg::iwd_decode_type dec,
  input wire logic               wait_second
);
  // A tagged word never opens an instruction, so it stays out of the one-word cases
  wire logic take = instr_valid && !flush;
  wire logic tagd = instr_word[15:12] == 4'hF;
  wire logic solo = take && !wait_second && !tagd;
  wire logic byt  = solo && instr_fmt == iwd_pkg::FMT_BYTE;
  wire logic bit1 = solo && instr_fmt == iwd_pkg::FMT_BIT;
  logic [WORD_W-1:0] w_q;
  // Word of the last edge, read back in the consequents
  always_ff @(posedge ref_clk) w_q <= instr_word;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////
  AST_BYTE: assert property (byt |=> dec.valid && dec.opcode == {2'h0, w_q[15:10]}
      && dec.dest == w_q[9]) else $error("bad byte fields");
  AST_BANK: assert property (byt || bit1 |=> dec.bank == w_q[8])
    else $error("bad bank select");
  AST_FILE: assert property (byt || bit1 |=> dec.file_addr == w_q[7:0])
    else $error("bad file address");
  AST_BIT: assert property (bit1 |=> dec.opcode == {4'h0, w_q[15:12]}
      && dec.bit_num == w_q[11:9]) else $error("bad bit fields");
  AST_MASK: assert property (dec.valid && dec.fmt == iwd_pkg::FMT_BIT && !dec.is_nop
      |-> dec.bit_mask == 8'h01 << dec.bit_num) else $error("bad bit mask");
  AST_LIT: assert property (solo && instr_fmt == iwd_pkg::FMT_LIT
      |=> dec.opcode == w_q[15:8] && dec.literal == w_q[7:0]) else $error("bad literal");
  AST_FIRST: assert property (solo && instr_fmt inside {iwd_pkg::FMT_MOVE,
      iwd_pkg::FMT_JUMP, iwd_pkg::FMT_CALL} |=> wait_second && !dec.valid)
    else $error("first word not held");
  AST_SECOND: assert property (take && wait_second && tagd |=> dec.valid && !wait_second
      && (dec.fmt == iwd_pkg::FMT_MOVE ? dec.dst_addr : dec.target[19:8]) == w_q[11:0])
    else $error("bad second word");
  AST_BRANCH: assert property (solo && instr_fmt == iwd_pkg::FMT_BRANCH
      |=> dec.rel_offset == {{9{w_q[10]}}, w_q[10:0]}) else $error("bad offset");
  AST_NOP: assert property (take && !wait_second && tagd
      |=> dec.valid && dec.is_nop && dec.fmt == iwd_pkg::FMT_OTHER) else $error("no nop");
endmodule // iwd_decoder_chk

bind iwd_decoder iwd_decoder_chk #(.WORD_W(WORD_W)) u_chk (
  .ref_clk(ref_clk), .rstn(rstn), .instr_valid(instr_valid), .instr_word(instr_word),
  .instr_fmt(instr_fmt), .flush(flush), .dec(dec), .wait_second(wait_second));

/* File: tb/iwd_fetch_model.sv */
`timescale 1ns/1ps
module iwd_fetch_model (
  // Clock
  input wire logic             ref_clk,
  // Words toward the decoder
  output logic                 instr_valid,
  output logic [15:0]          instr_word,
  output iwd_pkg::iwd_fmt_type instr_fmt
);
  // Idle bus, so nothing is taken before the first request
  initial begin
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    instr_fmt = iwd_pkg::FMT_OTHER;
  end
  // One word per falling edge; an idle bus flips its lines so a stale word never matches
  task automatic put(input logic v, input logic [15:0] w, input iwd_pkg::iwd_fmt_type f);
    @(negedge ref_clk);
    instr_valid = v;
    instr_word = v ? w : ~instr_word;
    instr_fmt = v ? f : iwd_pkg::iwd_fmt_type'(~instr_fmt);
  endtask
endmodule // iwd_fetch_model

/* File: tb/instruction_word_field_decoder_tb_top.sv */
`timescale 1ns/1ps
module instruction_word_field_decoder_tb_top;
  logic        ref_clk, rstn, flush, instr_valid, wait_second, pws;
  logic [15:0] instr_word;
  logic [31:0] seed;
  int          error_cnt, checks, cyc;
  logic [15:0] cw [8] = '{16'h1A55, 16'h1DAA, 16'h9E00, 16'h8100, 16'h0EFF, 16'hD7FF,
                          16'hD3FF, 16'h0000};
  logic [2:0]  cf [8] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h6, 3'h6, 3'h7};
  logic [2:0]  sf [5] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h7};
  iwd_pkg::iwd_fmt_type    instr_fmt;
  iwd_pkg::iwd_decode_type dec, pe, pm, all_m, idle_m, nop_m, err_m, nop_e, err_e;

  iwd_decoder #(.WORD_W(16)) uut (
    .ref_clk(ref_clk), .rstn(rstn), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_fmt(instr_fmt), .flush(flush), .dec(dec), .wait_second(wait_second));
  iwd_fetch_model fm (
    .ref_clk(ref_clk), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_fmt(instr_fmt));
  ////////////////////////////////
  // Clock and hang guard; the run needs a few hundred cycles
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Random words never carry the second-word tag unless a scenario wants it
  function automatic logic [15:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    return {seed[23:20] == 4'hF ? 4'h7 : seed[23:20], seed[19:8]};
  endfunction
  // Expected decode of a word, or of a pair whose second word is v
  function automatic iwd_pkg::iwd_decode_type ex(input logic [15:0] w, v, input logic [2:0] f);
    iwd_pkg::iwd_decode_type e;
    e = '0;
    e.valid = 1'b1;
    e.fmt = iwd_pkg::iwd_fmt_type'(f);
    e.opcode = w[15:8];
    case (f)
      3'h0: {e.opcode, e.file_addr} = {2'h0, w[15:10], w[7:0]};
      3'h1: {e.opcode, e.bit_num, e.file_addr} = {4'h0, w[15:9], w[7:0]};
      3'h2: e.literal = w[7:0];
      3'h3: {e.opcode, e.src_addr, e.dst_addr} = {4'h0, w, v[11:0]};
      3'h4: e.target = {v[11:0], w[7:0]};
      3'h5: {e.opcode, e.fast_flag, e.target} = {1'h0, w[15:8], v[11:0], w[7:0]};
      3'h6: {e.opcode, e.rel_offset} = {3'h0, w[15:11], {9{w[10]}}, w[10:0]};
      default: ;
    endcase
    if (f < 3'h2) e.bank = iwd_pkg::iwd_bank_type'(w[8]);
    if (f == 3'h0) e.dest = iwd_pkg::iwd_dest_type'(w[9]);
    if (f == 3'h1) e.bit_mask = 8'h01 << w[11:9];
    return e;
  endfunction
  ////////////////////////////////
  task automatic cmp_dec(input iwd_pkg::iwd_decode_type e, m);
    checks++;
    if ((dec & m) !== (e & m)) begin
      error_cnt++;
      $display("BAD t=%0t exp=%h got=%h", $time, e & m, dec & m);
    end
  endtask
  task automatic cmp_ws(input logic e);
    checks++;
    if (wait_second !== e) begin
      error_cnt++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, wait_second);
    end
  endtask
  // Drive one cycle, then judge what the previous cycle's word produced
  task automatic go(input logic v, fl, input logic [15:0] w, input logic [2:0] f,
                    input iwd_pkg::iwd_decode_type e, m, input logic ws);
    fm.put(v, w, iwd_pkg::iwd_fmt_type'(f));
    flush = fl;
    cmp_dec(pe, pm);
    cmp_ws(pws);
    pe = e;
    pm = m;
    pws = ws;
  endtask
  task automatic one(input logic [15:0] w, input logic [2:0] f);
    go(1'b1, 1'b0, w, f, ex(w, 16'h0, f), all_m, 1'b0);
  endtask
  task automatic idle();
    go(1'b0, 1'b0, 16'h0, 3'h7, '0, idle_m, 1'b0);
  endtask
  // Second word is sent with a wrong format, which the decoder must ignore
  task automatic pair(input logic [15:0] a, b, input logic [2:0] f, input int gap);
    go(1'b1, 1'b0, a, f, '0, idle_m, 1'b1);
    repeat (gap) go(1'b0, 1'b0, 16'h0, 3'h7, '0, idle_m, 1'b1);
    go(1'b1, 1'b0, {4'hF, b[11:0]}, 3'h0, ex(a, b, f), all_m, 1'b0);
  endtask
  ////////////////////////////////
  initial begin
    rstn = 1'b0;
    flush = 1'b0;
    seed = 32'h090FB607;
    pws = 1'b0;
    pe = '0;
    all_m = '1;
    // Without a valid record the format field follows the fetch path, so it is masked
    idle_m = '1;
    idle_m.fmt = iwd_pkg::FMT_BYTE;
    pm = idle_m;
    nop_m = '0;
    {nop_m.valid, nop_m.is_nop} = '1;
    nop_m.fmt = iwd_pkg::FMT_OTHER;
    err_m = nop_m;
    {err_m.pair_error, err_m.opcode} = '1;
    nop_e = nop_m;
    err_e = nop_e;
    {err_e.pair_error, err_e.opcode} = {1'b1, 8'hEF};
    err_e.fmt = iwd_pkg::FMT_JUMP;
    repeat (8) @(negedge ref_clk);
    cmp_dec('0, all_m);
    cmp_ws(1'b0);
    rstn = 1'b1;
    $display("reset test done");
    foreach (cw[i]) one(cw[i], cf[i]);
    for (int i = 0; i < 100; i++) begin
      one(rnd(), sf[i % 5]);
      if (seed[1]) idle();
    end
    $display("single word test done");
    pair(16'hEF34, 16'hF123, 3'h4, 0);
    pair(16'hEDFF, 16'hFFFF, 3'h5, 1);
    for (int i = 0; i < 30; i++) pair(rnd(), rnd(), 3'h3 + 3'(i % 3), i % 3);
    $display("pair test done");
    go(1'b1, 1'b0, 16'hF123, 3'h0, nop_e, nop_m, 1'b0);
    go(1'b1, 1'b0, 16'hEF34, 3'h4, '0, idle_m, 1'b1);
    go(1'b1, 1'b0, 16'h1234, 3'h0, err_e, err_m, 1'b0);
    go(1'b1, 1'b0, 16'h0C12, 3'h3, '0, idle_m, 1'b1);
    go(1'b1, 1'b1, 16'hF456, 3'h0, '0, idle_m, 1'b0);
    go(1'b1, 1'b0, 16'h0C12, 3'h3, '0, idle_m, 1'b1);
    idle();
    rstn = 1'b0;
    idle();
    rstn = 1'b1;
    go(1'b1, 1'b0, 16'hF0AA, 3'h3, nop_e, nop_m, 1'b0);
    idle();
    idle();
    $display("nop flush reset test done");
    report_and_stop();
  end
endmodule // instruction_word_field_decoder_tb_top
